// *** hw/lcdrw_top.sv ***
// pixel store, write pointer, serial byte receiver and row scan
`timescale 1ns/1ps

module lcdrw_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta_q <= INIT;
            sync_q <= INIT;
        end
        else
        begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule : lcdrw_sync

module lcdrw_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW:0] wr_q, wr_d, rd_q, rd_d;

    assign in_ready = !((wr_q[AW] != rd_q[AW]) &&
        (wr_q[AW-1:0] == rd_q[AW-1:0]));
    assign out_valid = (wr_q != rd_q);
    assign out_data = mem[rd_q[AW-1:0]];

    always_comb
    begin
        wr_d = wr_q;
        rd_d = rd_q;
        if (in_valid && in_ready)
            wr_d = wr_q + 1'b1;
        if (out_valid && out_ready)
            rd_d = rd_q + 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wr_q <= '0;
            rd_q <= '0;
        end
        else
        begin
            wr_q <= wr_d;
            rd_q <= rd_d;
        end
        if (in_valid && in_ready)
            mem[wr_q[AW-1:0]] <= in_data;
    end
endmodule : lcdrw_fifo

// How it works
// - pixel store: eight byte banks of 102 entries plus one bit bank
// - write pointer has 7-bit column and 4-bit bank, each set alone
// - every stored data byte steps the pointer once, order by flag
// - column-first: bank steps, after bank 8 wraps and column steps
// - row-first: column steps, after column 101 wraps and bank steps
// - write at column 101, bank 8 wraps both fields to zero
// - column address n drives column output n
// - serial bits taken only while select is low
// - command/data level routes each byte to command or pixel store
// - display look comes from the two look bits of display control
// - display timing runs on regardless of serial traffic
// - panel refreshed by reading store row by row to column outputs
// - display clock internal when source pin high, else pin clock
// - serial clock accepted at any rate up to 4 Mbit/s
// - command/data level sampled with eighth serial clock; low is command
// - serial data sampled on rising serial clock, msb first
// - look 00 blank, 10 normal, 01 all on, 11 inverse
// - bank 8 stores only the data byte's lsb
module lcdrw_top
    import lcdrw_pkg::*;
(
    // system
    input wire logic CLK_SYS,
    input wire logic RST,
    // pins from the host and the board
    input wire logic EXTERNAL_CLEAR_N,
    input wire logic LINK_SELECT_N,
    input wire logic SERIAL_CLOCK,
    input wire logic SERIAL_BIT_INPUT,
    input wire logic DATA_SELECT,
    input wire logic CLOCK_SOURCE_PIN,
    // panel drive
    output logic [COLS-1:0] COLUMN_DATA,
    output logic [6:0] ROW_INDEX,
    output logic ROW_STROBE,
    // status
    output logic [1:0] LOOK_MODE,
    output logic SLEEP_FLAG,
    output logic VERTICAL_MODE,
    output logic EXTENDED_SET,
    output logic [6:0] WRITE_X,
    output logic [3:0] WRITE_Y,
    output logic FIFO_READY
);
    logic res_n, sce_n, sclk, serial_bit_input, dc, osc;
    logic clr;
    lcdrw_sync #(.WIDTH(6), .INIT(6'h3C)) u_sync (
        .clk(CLK_SYS),
        .rst(RST),
        .async_in({EXTERNAL_CLEAR_N, LINK_SELECT_N, SERIAL_CLOCK,
            SERIAL_BIT_INPUT, DATA_SELECT, CLOCK_SOURCE_PIN}),
        .sync_out({res_n, sce_n, sclk, serial_bit_input, dc, osc})
    );
    assign clr = RST || !res_n;

    // serial receiver
    logic sclk_prev_q, osc_prev_q;
    logic [7:0] shift_q, shift_d;
    logic [2:0] cnt_q, cnt_d;
    logic sclk_rise, push;
    lcdrw_byte_s in_byte, out_byte;
    logic in_ready, out_valid, out_ready, take;

    // a 4 Mbit/s clock gives 125 ns high and low, many samples at 5 ns
    assign sclk_rise = sclk && !sclk_prev_q;
    assign push = sclk_rise && !sce_n && (cnt_q == BIT_LAST);
    assign in_byte.value = {shift_q[6:0], serial_bit_input};
    assign in_byte.is_data = dc;

    always_comb
    begin
        shift_d = shift_q;
        cnt_d = cnt_q;
        if (sce_n)
            cnt_d = 3'h0;
        else if (sclk_rise)
        begin
            shift_d = {shift_q[6:0], serial_bit_input};
            cnt_d = cnt_q + 3'h1;
        end
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (clr)
        begin
            shift_q <= 8'h00;
            cnt_q <= 3'h0;
            // sclk_prev_q matches the synchroniser's reset level and osc_prev_q starts high, so no false edge
            sclk_prev_q <= 1'b1;
            osc_prev_q <= 1'b1;
        end
        else
        begin
            shift_q <= shift_d;
            cnt_q <= cnt_d;
            sclk_prev_q <= sclk;
            osc_prev_q <= osc;
        end
    end

    // a clear flushes bytes still queued, so none reaches the store
    lcdrw_fifo #(.WIDTH($bits(lcdrw_byte_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(CLK_SYS),
        .rst(clr),
        .in_valid(push),
        .in_data(in_byte),
        .in_ready(in_ready),
        .out_valid(out_valid),
        .out_data(out_byte),
        .out_ready(out_ready)
    );
    assign FIFO_READY = in_ready;

    // command decode and write pointer
    lcdrw_scan_e scan_q, scan_d;
    lcdrw_ptr_s ptr_q, ptr_d;
    logic v_q, v_d, h_q, h_d, sleep_q, sleep_d;
    logic [1:0] look_q, look_d;
    logic wr_full, wr_bit;
    logic [7:0] bank_mem [0:FULL_BANKS*COLS-1];
    logic [COLS-1:0] bit_bank;

    // draining pauses while the scan reads the store
    assign out_ready = (scan_q != SC_READ);
    assign take = out_valid && out_ready;
    assign wr_full = take && out_byte.is_data && (ptr_q.y != Y_LAST);
    assign wr_bit = take && out_byte.is_data && (ptr_q.y == Y_LAST);

    always_comb
    begin
        ptr_d = ptr_q;
        v_d = v_q;
        h_d = h_q;
        sleep_d = sleep_q;
        look_d = look_q;
        if (take && out_byte.is_data)
        begin
            if (ptr_q.x == X_LAST && ptr_q.y == Y_LAST)
                ptr_d = '0;
            else if (v_q)
            begin
                if (ptr_q.y == Y_LAST)
                begin
                    ptr_d.y = 4'h0;
                    ptr_d.x = ptr_q.x + 7'h01;
                end
                else
                    ptr_d.y = ptr_q.y + 4'h1;
            end
            else if (ptr_q.x == X_LAST)
            begin
                ptr_d.x = 7'h00;
                ptr_d.y = ptr_q.y + 4'h1;
            end
            else
                ptr_d.x = ptr_q.x + 7'h01;
        end
        else if (take)
        begin
            if (out_byte.value[7:3] == CMD_FSET_TOP)
            begin
                sleep_d = out_byte.value[FS_SLEEP_BIT];
                v_d = out_byte.value[FS_V_BIT];
                h_d = out_byte.value[FS_H_BIT];
            end
            else if (!h_q && out_byte.value[CMD_SETX_BIT])
                ptr_d.x = out_byte.value[6:0];
            else if (!h_q && out_byte.value[7:4] == CMD_SETY_TOP)
                ptr_d.y = out_byte.value[3:0];
            else if (!h_q && out_byte.value[7:3] == CMD_DCTL_TOP &&
                !out_byte.value[DC_ZERO_BIT])
                look_d = {out_byte.value[DC_D_BIT],
                    out_byte.value[DC_E_BIT]};
        end
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (clr)
        begin
            ptr_q <= {Y_RST, X_RST};
            v_q <= V_RST;
            h_q <= H_RST;
            sleep_q <= SLEEP_RST;
            look_q <= LOOK_RST;
        end
        else
        begin
            ptr_q <= ptr_d;
            v_q <= v_d;
            h_q <= h_d;
            sleep_q <= sleep_d;
            look_q <= look_d;
        end
    end

    // the store keeps its contents through any reset
    always_ff @(posedge CLK_SYS)
    begin
        if (wr_full)
            bank_mem[ptr_q.y * COLS + ptr_q.x] <= out_byte.value;
        if (wr_bit)
            bit_bank[ptr_q.x] <= out_byte.value[0];
    end

    // display clock and row scan
    logic [8:0] hold_q, hold_d;
    logic [11:0] div_q, div_d;
    logic int_osc, tick;
    logic [6:0] row_q, row_d, col_q, col_d, row_out_q, row_out_d;
    logic [COLS-1:0] rowbuf_q, rowbuf_d, colout_q, colout_d;
    logic strobe_q, strobe_d, rd_bit;
    logic [3:0] rd_bank;

    // the pin counts as tied high once it has stayed high for a while;
    // an external clock slower than that would be taken for the tie
    assign int_osc = (hold_q == 9'(OSC_HOLD_CYC));
    assign tick = !sleep_q && (int_osc ? (div_q == 12'(INT_ROW_CYC - 1))
        : (osc && !osc_prev_q));
    assign rd_bank = {1'b0, row_q[5:3]};
    assign rd_bit = row_q[6] ? bit_bank[col_q]
        : bank_mem[rd_bank * COLS + col_q][row_q[2:0]];

    always_comb
    begin
        hold_d = osc ? (int_osc ? hold_q : hold_q + 9'h001) : 9'h000;
        div_d = (!int_osc || div_q == 12'(INT_ROW_CYC - 1)) ? 12'h000
            : div_q + 12'h001;
        scan_d = scan_q;
        row_d = row_q;
        col_d = col_q;
        rowbuf_d = rowbuf_q;
        colout_d = sleep_q ? '0 : colout_q;
        row_out_d = row_out_q;
        strobe_d = 1'b0;
        case (scan_q)
            SC_IDLE:
                if (tick)
                begin
                    scan_d = SC_READ;
                    col_d = 7'h00;
                end
            SC_READ:
            begin
                rowbuf_d[col_q] = rd_bit;
                if (col_q == X_LAST)
                    scan_d = SC_SHOW;
                else
                    col_d = col_q + 7'h01;
            end
            SC_SHOW:
            begin
                scan_d = SC_IDLE;
                strobe_d = 1'b1;
                row_out_d = row_q;
                row_d = (row_q == ROW_LAST) ? 7'h00 : row_q + 7'h01;
                case (look_q)
                    LOOK_NORMAL: colout_d = rowbuf_q;
                    LOOK_ALLON: colout_d = '1;
                    LOOK_INVERSE: colout_d = ~rowbuf_q;
                    default: colout_d = '0;
                endcase
                if (sleep_q)
                    colout_d = '0;
            end
            default: scan_d = SC_IDLE;
        endcase
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (clr)
        begin
            hold_q <= 9'h000;
            div_q <= 12'h000;
            scan_q <= SC_IDLE;
            row_q <= 7'h00;
            col_q <= 7'h00;
            rowbuf_q <= '0;
            colout_q <= '0;
            row_out_q <= 7'h00;
            strobe_q <= 1'b0;
        end
        else
        begin
            hold_q <= hold_d;
            div_q <= div_d;
            scan_q <= scan_d;
            row_q <= row_d;
            col_q <= col_d;
            rowbuf_q <= rowbuf_d;
            colout_q <= colout_d;
            row_out_q <= row_out_d;
            strobe_q <= strobe_d;
        end
    end

    assign COLUMN_DATA = colout_q;
    assign ROW_INDEX = row_out_q;
    assign ROW_STROBE = strobe_q;
    assign LOOK_MODE = look_q;
    assign SLEEP_FLAG = sleep_q;
    assign VERTICAL_MODE = v_q;
    assign EXTENDED_SET = h_q;
    assign WRITE_X = ptr_q.x;
    assign WRITE_Y = ptr_q.y;

    // checks
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (clr);

    ptr_row_first_a: assert property (take && out_byte.is_data && !v_q &&
        ptr_q.x != X_LAST |=> ptr_q.x == $past(ptr_q.x) + 7'h01 &&
        ptr_q.y == $past(ptr_q.y))
        else $error("row-first step wrong");
    ptr_row_wrap_a: assert property (take && out_byte.is_data && !v_q &&
        ptr_q.x == X_LAST && ptr_q.y != Y_LAST |=> ptr_q.x == 7'h00 &&
        ptr_q.y == $past(ptr_q.y) + 4'h1)
        else $error("row-first wrap wrong");
    ptr_col_first_a: assert property (take && out_byte.is_data && v_q &&
        ptr_q.y == Y_LAST && ptr_q.x != X_LAST |=> ptr_q.y == 4'h0 &&
        ptr_q.x == $past(ptr_q.x) + 7'h01)
        else $error("column-first wrap wrong");
    ptr_full_wrap_a: assert property (take && out_byte.is_data &&
        ptr_q.x == X_LAST && ptr_q.y == Y_LAST |=> ptr_q == '0)
        else $error("last address did not wrap");
    set_col_a: assert property (take && !out_byte.is_data && !h_q &&
        out_byte.value[7] |=> ptr_q.x == $past(out_byte.value[6:0]) &&
        ptr_q.y == $past(ptr_q.y))
        else $error("column load wrong");
    select_gate_a: assert property (sce_n |-> !push ##1 cnt_q == 3'h0)
        else $error("bits taken while deselected");
    bit_bank_a: assert property (wr_bit |=>
        bit_bank[$past(ptr_q.x)] == $past(out_byte.value[0]))
        else $error("bit bank store wrong");
    // the shown row was built from the look of the cycle before the strobe
    look_allon_a: assert property (ROW_STROBE &&
        $past(look_q) == LOOK_ALLON && !$past(sleep_q) |->
        COLUMN_DATA == '1)
        else $error("all-on look wrong");
    scan_span_a: assert property ($rose(scan_q == SC_READ) |->
        ##103 ROW_STROBE)
        else $error("row strobe late or early");

    wrap_vert_c: cover property (take && out_byte.is_data && v_q &&
        ptr_q.y == Y_LAST);
    inverse_c: cover property (ROW_STROBE && look_q == LOOK_INVERSE);
    fifo_full_c: cover property (!in_ready);
    ext_tick_c: cover property (tick && !int_osc);
endmodule : lcdrw_top

// *** hw/lcdrw_pkg.sv ***
// shared constants and types for the lcd pixel store write path
package lcdrw_pkg;

    // pixel store geometry
    localparam int COLS = 102;
    localparam int FULL_BANKS = 8;
    localparam int FIFO_DEPTH = 16;
    localparam logic [6:0] X_LAST = 7'h65;
    localparam logic [3:0] Y_LAST = 4'h8;
    localparam logic [6:0] ROW_LAST = 7'h40;
    localparam logic [2:0] BIT_LAST = 3'h7;

    // values after reset
    localparam logic [6:0] X_RST = 7'h00;
    localparam logic [3:0] Y_RST = 4'h0;
    localparam logic V_RST = 1'b0;
    localparam logic H_RST = 1'b0;
    localparam logic SLEEP_RST = 1'b1;
    localparam logic [1:0] LOOK_RST = 2'h0;

    // command byte layout
    localparam logic [4:0] CMD_FSET_TOP = 5'h04;
    localparam logic [4:0] CMD_DCTL_TOP = 5'h01;
    localparam logic [3:0] CMD_SETY_TOP = 4'h4;
    localparam int CMD_SETX_BIT = 7;
    localparam int FS_SLEEP_BIT = 2;
    localparam int FS_V_BIT = 1;
    localparam int FS_H_BIT = 0;
    localparam int DC_D_BIT = 2;
    localparam int DC_ZERO_BIT = 1;
    localparam int DC_E_BIT = 0;

    // timing at the 200 MHz system clock
    localparam int SYS_CLK_PS = 5000;
    localparam int INT_ROW_NS = 16000;
    localparam int INT_ROW_CYC = (INT_ROW_NS * 1000) / SYS_CLK_PS;
    localparam int OSC_HOLD_NS = 2000;
    localparam int OSC_HOLD_CYC = (OSC_HOLD_NS * 1000 + SYS_CLK_PS - 1)
        / SYS_CLK_PS;

    // display look codes, {d, e}
    typedef enum logic [1:0] {
        LOOK_BLANK = 2'h0,
        LOOK_ALLON = 2'h1,
        LOOK_NORMAL = 2'h2,
        LOOK_INVERSE = 2'h3
    } lcdrw_look_e;

    typedef enum logic [2:0] {
        SC_IDLE = 3'h1,
        SC_READ = 3'h2,
        SC_SHOW = 3'h4
    } lcdrw_scan_e;

    typedef struct packed {
        logic is_data;
        logic [7:0] value;
    } lcdrw_byte_s;

    typedef struct packed {
        logic [3:0] y;
        logic [6:0] x;
    } lcdrw_ptr_s;

endpackage : lcdrw_pkg

// *** testbench/lcdrw_host.sv ***
// host model that drives bytes over the serial write link
`timescale 1ns/1ps

module lcdrw_host (
    // clock
    input wire logic clk,
    // serial link
    output logic sel_n,
    output logic sclk,
    output logic sdi,
    output logic dc
);
    initial
    begin
        sel_n = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
        dc = 1'b0;
    end

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask : idle

    // nbits below 8 cuts the byte short; quiet keeps select high
    task automatic send(input logic is_d, input logic [7:0] v,
                        input int nbits, input logic quiet, input int hp);
        @(posedge clk);
        sel_n <= quiet;
        dc <= is_d;
        for (int i = 7; i > 7 - nbits; i--)
        begin
            sdi <= v[i];
            idle(hp);
            sclk <= 1'b1;
            idle(hp + 1);
            sclk <= 1'b0;
        end
        idle(hp);
        sel_n <= 1'b1;
        // released lines flip so a stale level cannot pass for a good one
        sdi <= ~sdi;
        dc <= ~dc;
        // room for sync, fifo and a scan stall of a whole row read
        idle(130);
    endtask : send
endmodule : lcdrw_host

// *** testbench/lcd_ram_write_addressing_tb.sv ***
// self-checking bench for the lcd pixel store write path
`timescale 1ns/1ps

module lcd_ram_write_addressing_tb
    import lcdrw_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic clear_n = 1'b1;
    logic osc_pin = 1'b0;
    logic sel_n, sclk, sdi, dc, row_stb, sleep, vmode, ext, fifo_rdy;
    logic [COLS-1:0] col_data;
    logic [6:0] row_idx, wx;
    logic [3:0] wy;
    logic [1:0] look;
    logic scan_on = 1'b0;
    logic px_on = 1'b0;
    logic [6:0] row_exp = 7'h00;
    logic [7:0] pat = 8'hA5;
    logic inv_on = 1'b0;
    logic allon_on = 1'b0;
    logic osc_tie = 1'b0;
    int n_fail = 0;
    int n_compared = 0;
    int rows_seen = 0;
    int gap_cnt = 0;
    int row_gap = 0;

    always #2.5 clk_sys = ~clk_sys;

    lcdrw_top dut (
        .CLK_SYS(clk_sys), .RST(rst), .EXTERNAL_CLEAR_N(clear_n),
        .LINK_SELECT_N(sel_n), .SERIAL_CLOCK(sclk),
        .SERIAL_BIT_INPUT(sdi), .DATA_SELECT(dc),
        .CLOCK_SOURCE_PIN(osc_pin), .COLUMN_DATA(col_data),
        .ROW_INDEX(row_idx), .ROW_STROBE(row_stb), .LOOK_MODE(look),
        .SLEEP_FLAG(sleep), .VERTICAL_MODE(vmode), .EXTENDED_SET(ext),
        .WRITE_X(wx), .WRITE_Y(wy), .FIFO_READY(fifo_rdy)
    );

    lcdrw_host host (
        .clk(clk_sys), .sel_n(sel_n), .sclk(sclk), .sdi(sdi), .dc(dc)
    );

    task automatic stop_test;
        if (n_fail == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : stop_test

    task automatic fail(input string msg);
        n_fail++;
        $display("[ERR] %0t %s", $time, msg);
    endtask : fail

    task automatic chk(input logic ok, input string msg);
        n_compared++;
        if (ok !== 1'b1)
            fail(msg);
    endtask : chk

    task automatic cmd(input logic [7:0] v);
        host.send(1'b0, v, 8, 1'b0, 12);
    endtask : cmd

    task automatic put(input logic [7:0] v);
        host.send(1'b1, v, 8, 1'b0, 12);
    endtask : put

    task automatic go(input logic [6:0] x, input logic [3:0] y);
        cmd({1'b1, x});
        cmd({CMD_SETY_TOP, y});
    endtask : go

    task automatic pulse_clear;
        @(posedge clk_sys);
        clear_n <= 1'b0;
        repeat (4) @(posedge clk_sys);
        clear_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
    endtask : pulse_clear

    task automatic wait_rows(input int n);
        for (int i = 0; i < 150 * n && rows_seen < n; i++)
            @(posedge clk_sys);
        if (rows_seen < n)
        begin
            fail("row strobe missing");
            stop_test();
        end
    endtask : wait_rows

    function automatic lcdrw_ptr_s step(input lcdrw_ptr_s p, input logic v);
        if (p.x == X_LAST && p.y == Y_LAST)
            return '0;
        if (v)
            return (p.y == Y_LAST) ? {4'h0, p.x + 7'h01}
                : {p.y + 4'h1, p.x};
        return (p.x == X_LAST) ? {p.y + 4'h1, 7'h00}
            : {p.y, p.x + 7'h01};
    endfunction : step

    task automatic run_case(input logic v, input logic [6:0] x,
                            input logic [3:0] y, input int n);
        lcdrw_ptr_s p;
        p = {y, x};
        cmd({CMD_FSET_TOP, 1'b0, v, 1'b0});
        chk(vmode === v, "order flag");
        go(x, y);
        chk(wx === p.x && wy === p.y, "pointer load");
        repeat (n)
        begin
            put(8'($urandom));
            p = step(p, v);
            chk(wx === p.x && wy === p.y, "pointer step");
        end
    endtask : run_case

    // the fifo drains far faster than the link fills it, so it never fills
    task automatic fifo_test;
        go(7'h20, 4'h1);
        for (int i = 1; i < 4; i++)
        begin
            chk(fifo_rdy === 1'b1, "fifo ready");
            put(8'($urandom));
            chk(wx === 7'h20 + 7'(i) && wy === 4'h1, "fifo pass");
            chk(fifo_rdy === 1'b1, "fifo drained");
        end
    endtask : fifo_test

    // external row clock; pin stays far below the internal-select hold
    always
    begin
        repeat (60) @(posedge clk_sys);
        // a pin held high selects the internal row clock
        if (osc_tie)
            osc_pin <= 1'b1;
        else if (scan_on)
            osc_pin <= ~osc_pin;
    end

    always @(posedge clk_sys)
    begin
        gap_cnt++;
        if (row_stb === 1'b1)
        begin
            row_gap = gap_cnt;
            gap_cnt = 0;
            chk(row_idx === row_exp, "row order");
            if (px_on && row_idx < 7'h08)
                chk(col_data[3] === (pat[row_idx] ^ inv_on),
                    "bank pixel");
            if (px_on && row_idx == ROW_LAST)
                chk(col_data[6:5] === (2'b10 ^ {2{inv_on}}),
                    "bit bank pixel");
            if (allon_on)
                chk(col_data === '1, "all-on look");
            row_exp <= (row_exp == ROW_LAST) ? 7'h00 : row_exp + 7'h01;
            rows_seen++;
        end
    end

    initial
    begin
        void'($urandom(32'h6272));
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        chk(sleep === SLEEP_RST && wx === X_RST && wy === Y_RST
            && look === LOOK_RST && vmode === V_RST && ext === H_RST
            && fifo_rdy === 1'b1, "reset state");
        pulse_clear();
        fifo_test();
        run_case(1'b0, 7'h64, 4'h0, 3);
        run_case(1'b0, 7'h65, 4'h3, 2);
        run_case(1'b0, X_LAST, Y_LAST, 2);
        run_case(1'b1, 7'h04, 4'h7, 3);
        run_case(1'b1, X_LAST, Y_LAST, 2);
        repeat (4) run_case(1'($urandom), 7'($urandom_range(101)),
            4'($urandom_range(8)), 6);
        go(7'h22, 4'h5);
        cmd({1'b1, 7'h11});
        chk(wx === 7'h11 && wy === 4'h5, "x alone");
        cmd({CMD_SETY_TOP, 4'h2});
        chk(wx === 7'h11 && wy === 4'h2, "y alone");
        host.send(1'b0, 8'h85, 8, 1'b1, 12);
        chk(wx === 7'h11, "bits while deselected");
        host.send(1'b0, 8'hFF, 5, 1'b0, 12);
        cmd({1'b1, 7'h33});
        chk(wx === 7'h33 && wy === 4'h2, "cut-off byte");
        host.send(1'b0, 8'h8A, 8, 1'b0, 40);
        chk(wx === 7'h0A, "slow link");
        cmd({CMD_FSET_TOP, 3'h1});
        chk(ext === 1'b1, "extended set");
        cmd({1'b1, 7'h44});
        chk(wx === 7'h0A, "x ignored when extended");
        cmd({CMD_FSET_TOP, 3'h0});
        for (int i = 0; i < 4; i++)
        begin
            cmd({CMD_DCTL_TOP, i[1], 1'b0, i[0]});
            chk(look === i[1:0], "look bits");
        end
        go(7'h03, 4'h0);
        put(pat);
        chk(wx === 7'h04 && wy === 4'h0, "data byte not command");
        go(7'h05, Y_LAST);
        put(8'hFE);
        put(8'h01);
        cmd({CMD_FSET_TOP, 3'h2});
        go(7'h09, 4'h4);
        pulse_clear();
        chk(wx === X_RST && wy === Y_RST && vmode === 1'b0
            && sleep === 1'b1, "external clear");
        cmd({CMD_FSET_TOP, 3'h0});
        cmd({CMD_DCTL_TOP, 3'h4});
        px_on <= 1'b1;
        scan_on <= 1'b1;
        wait_rows(66);
        // pixel checks stay off while the look changes in mid-transfer
        px_on <= 1'b0;
        cmd({CMD_DCTL_TOP, 3'h5});
        px_on <= 1'b1;
        inv_on <= 1'b1;
        wait_rows(rows_seen + 8);
        px_on <= 1'b0;
        cmd({CMD_DCTL_TOP, 3'h1});
        allon_on <= 1'b1;
        wait_rows(rows_seen + 2);
        allon_on <= 1'b0;
        run_case(1'b1, 7'h10, 4'h2, 4);
        wait_rows(rows_seen + 3);
        // up to two leftover strobes precede the internal ones
        scan_on <= 1'b0;
        osc_tie <= 1'b1;
        wait_rows(rows_seen + 4);
        chk(row_gap == INT_ROW_CYC, "internal row period");
        cmd({CMD_FSET_TOP, 3'h4});
        chk(col_data === '0, "sleep blanks columns");
        osc_tie <= 1'b0;
        stop_test();
    end
endmodule : lcd_ram_write_addressing_tb
